/* logic/cpm_clock_power_ctrl.sv */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
// Clock source, core divider and power mode controller with key locks.
module cpm_clock_power_ctrl
   import cpm_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address channel.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Asynchronous inputs from pins and the analog PLL.
   input wire logic pll_locked,
   input wire logic ext_clock_pin,
   input wire logic [3:0] external_irq_lines,
   // Event from the second timer, same clock domain.
   input wire logic second_timer_event,
   // Clock system controls.
   output logic ref_internal_sel,
   output logic [1:0] clock_source_mode,
   output logic core_clk_en,
   output logic core_halted,
   // Power domain enables.
   output cpm_domains_t domains,
   // Interrupt.
   output logic irq
);

   localparam int NUM_ASYNC = 6; // Lock, external clock, four lines.

   logic [NUM_ASYNC-1:0] async_in; // Raw asynchronous inputs.
   logic [NUM_ASYNC-1:0] sync1_ff; // First stage, read only by stage two.
   logic [NUM_ASYNC-1:0] sync2_ff; // Second stage.
   logic [NUM_ASYNC-1:0] sync3_ff; // Third stage.
   logic [NUM_ASYNC-1:0] stable_ff; // Accepted level after agreement.
   logic [NUM_ASYNC-1:0] stable_d_ff; // Accepted level one cycle ago.

   logic aw_have_ff; // Write address captured.
   logic w_have_ff; // Write data captured.
   logic [31:0] aw_addr_ff; // Captured write address.
   logic [31:0] w_data_ff; // Captured write data.
   logic w_lane0_ff; // Low byte lane was enabled.
   logic wr_go; // The captured write executes this cycle.
   cpm_wr_t wr; // The executing write.

   logic [7:0] clk_cfg_ff; // Clock configuration register.
   logic [7:0] pwr_cfg_ff; // Power configuration register.
   logic [7:0] clk_pend_ff; // Clock value waiting for its second key.
   logic [7:0] pwr_pend_ff; // Power value waiting for its second key.
   cpm_key_state_t clk_key_ff; // Clock unlock progress.
   cpm_key_state_t pwr_key_ff; // Power unlock progress.
   logic clk_commit; // Clock second key completes the sequence.
   logic pwr_commit; // Power second key completes the sequence.

   logic [EVT_W-1:0] stat_ff; // Sticky event status.
   logic [EVT_W-1:0] en_ff; // Interrupt enables.
   logic [EVT_W-1:0] evt; // Events raised this cycle.

   logic lock_st; // Synchronised PLL lock.
   logic ext_clk_rise; // Rising edge of the external clock.
   logic [3:0] irq_st; // Synchronised external lines.
   logic [2:0] pmode; // Current power mode.
   logic wake; // Wake condition for the current mode.
   logic src_tick; // Source tick ahead of the divider.
   logic core_halt; // Core clock must stand still.

   assign async_in = {pll_locked, ext_clock_pin, external_irq_lines};

   // Three-stage synchronisers; a new level counts once stages two and
   // three agree, which rejects a level that is still settling.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_ASYNC; gi++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
               sync3_ff[gi] <= 1'b0;
               stable_ff[gi] <= 1'b0;
               stable_d_ff[gi] <= 1'b0;
            end else begin
               sync1_ff[gi] <= async_in[gi];
               sync2_ff[gi] <= sync1_ff[gi];
               sync3_ff[gi] <= sync2_ff[gi];
               stable_d_ff[gi] <= stable_ff[gi];
               if (sync2_ff[gi] == sync3_ff[gi]) begin
                  stable_ff[gi] <= sync3_ff[gi];
               end
            end
         end
      end
   endgenerate

   assign lock_st = stable_ff[5];
   assign ext_clk_rise = stable_ff[4] && !stable_d_ff[4];
   assign irq_st = stable_ff[3:0];

   // Each address and data channel is taken once; the write runs when both
   // are held and no response is pending, so the order does not matter.
   assign s_axi_awready = !aw_have_ff;
   assign s_axi_wready = !w_have_ff;
   assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;
   assign wr.addr = aw_addr_ff;
   assign wr.data = w_lane0_ff ? w_data_ff : 32'h0000_0000;

   // Capture of address and data, released once the write executes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff <= '0;
         w_lane0_ff <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_lane0_ff <= s_axi_wstrb[0];
         end else if (wr_go) begin
            w_have_ff <= 1'b0;
         end
      end
   end

   // Write response one cycle after execution; unmapped answers SLVERR.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         case (aw_addr_ff)
            PWR_KEY1_ADDR, PWR_CFG_ADDR, PWR_KEY2_ADDR, CLK_KEY1_ADDR,
            CLK_CFG_ADDR, CLK_KEY2_ADDR, IRQ_STAT_ADDR, IRQ_CLR_ADDR,
            IRQ_EN_ADDR: s_axi_bresp <= RESP_OKAY;
            default: s_axi_bresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Next unlock state after any write. Any write that is not the
   // expected next step drops the sequence, so nothing may come between.
   function automatic cpm_key_state_t nxt_key(
      input cpm_key_state_t st,
      input cpm_wr_t w,
      input logic [31:0] k1_addr,
      input logic [15:0] k1_val,
      input logic [31:0] cfg_addr
   );
      logic k1_ok;
      k1_ok = (w.addr == k1_addr) && (w.data[15:0] == k1_val);
      case (st)
         KEY_ARMED: nxt_key = (w.addr == cfg_addr) ? KEY_HELD :
                              (k1_ok ? KEY_ARMED : KEY_IDLE);
         default: nxt_key = k1_ok ? KEY_ARMED : KEY_IDLE;
      endcase
   endfunction

   assign clk_commit = wr_go && (clk_key_ff == KEY_HELD) &&
                       (wr.addr == CLK_KEY2_ADDR) &&
                       (wr.data[15:0] == CLK_KEY2_VAL);
   assign pwr_commit = wr_go && (pwr_key_ff == KEY_HELD) &&
                       (wr.addr == PWR_KEY2_ADDR) &&
                       (wr.data[15:0] == PWR_KEY2_VAL);

   // Unlock progress and the held values of both protected registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_key_ff <= KEY_IDLE;
         pwr_key_ff <= KEY_IDLE;
         clk_pend_ff <= '0;
         pwr_pend_ff <= '0;
      end else if (wr_go) begin
         clk_key_ff <= nxt_key(clk_key_ff, wr, CLK_KEY1_ADDR, CLK_KEY1_VAL,
                               CLK_CFG_ADDR);
         pwr_key_ff <= nxt_key(pwr_key_ff, wr, PWR_KEY1_ADDR, PWR_KEY1_VAL,
                               PWR_CFG_ADDR);
         if (wr.addr == CLK_CFG_ADDR) begin
            clk_pend_ff <= wr.data[7:0] & CLK_CFG_MASK;
         end
         if (wr.addr == PWR_CFG_ADDR) begin
            pwr_pend_ff <= wr.data[7:0] & PWR_CFG_MASK;
         end
      end
   end

   // Clock configuration changes only when its sequence completes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_cfg_ff <= CLK_CFG_RST;
      end else if (clk_commit) begin
         clk_cfg_ff <= clk_pend_ff;
      end
   end

   assign pmode = pwr_cfg_ff[PWR_MODE_LSB +: 3];

   // Sleep listens to the lines and the second timer, stop only to the
   // lines. Pause and nap also wake on either, as they keep both alive.
   always_comb begin
      case (pmode)
         PM_PAUSE, PM_NAP: wake = (|irq_st) || second_timer_event;
         PM_SLEEP: wake = (|irq_st) || second_timer_event;
         PM_STOP: wake = |irq_st;
         default: wake = 1'b0;
      endcase
   end

   // Power configuration: key sequence, or a wake returns to active.
   // A sequence completing in the wake cycle wins as the newer request.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_cfg_ff <= PWR_CFG_RST;
      end else if (pwr_commit) begin
         pwr_cfg_ff <= pwr_pend_ff;
      end else if (wake) begin
         pwr_cfg_ff[PWR_MODE_LSB +: 3] <= PM_ACTIVE;
      end
   end

   assign ref_internal_sel = clk_cfg_ff[REF_SEL_BIT];
   assign clock_source_mode = clk_cfg_ff[SRC_MODE_LSB +: 2];

   // External mode ticks on the synchronised pin edge; every other code
   // runs from the PLL, which this clock stands in for.
   assign src_tick = (clock_source_mode == SRC_EXT) ? ext_clk_rise : 1'b1;
   assign core_halt = (pmode != PM_ACTIVE) ||
                      ((clock_source_mode != SRC_EXT) && !lock_st);
   assign core_halted = core_halt;

   // Core clock divider; the PLL output is the reference times PLL_MULT.
   cpm_core_divider u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .src_tick(src_tick),
      .halt(core_halt),
      .div_sel(pwr_cfg_ff[CORE_DIV_LSB +: 3]),
      .core_en(core_clk_en)
   );

   // Domain enables per power mode; reserved codes keep all powered.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         domains <= '1;
      end else begin
         case (pmode)
            PM_PAUSE: domains <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
            PM_NAP: domains <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
            PM_SLEEP: domains <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
            PM_STOP: domains <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            default: domains <= '1;
         endcase
      end
   end

   // Lock loss only counts while the PLL clocks the core.
   assign evt[EVT_UNLOCK] = stable_d_ff[5] && !lock_st &&
                            (clock_source_mode != SRC_EXT);
   assign evt[EVT_WAKE] = wake;

   // Sticky status: a new event wins over a clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_ff <= '0;
      end else if (wr_go && (wr.addr == IRQ_CLR_ADDR)) begin
         stat_ff <= (stat_ff & ~wr.data[EVT_W-1:0]) | evt;
      end else begin
         stat_ff <= stat_ff | evt;
      end
   end

   // Interrupt enables.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_ff <= '0;
      end else if (wr_go && (wr.addr == IRQ_EN_ADDR)) begin
         en_ff <= wr.data[EVT_W-1:0];
      end
   end

   assign irq = |(stat_ff & en_ff);

   // Reads answer one cycle after the address; keys and clear read zero.
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
         case (s_axi_araddr)
            CLK_CFG_ADDR: s_axi_rdata <= {24'h000000, clk_cfg_ff};
            PWR_CFG_ADDR: s_axi_rdata <= {24'h000000, pwr_cfg_ff};
            IRQ_STAT_ADDR: s_axi_rdata <= {30'h0, stat_ff};
            IRQ_EN_ADDR: s_axi_rdata <= {30'h0, en_ff};
            PWR_KEY1_ADDR, PWR_KEY2_ADDR, CLK_KEY1_ADDR, CLK_KEY2_ADDR,
            IRQ_CLR_ADDR: s_axi_rdata <= '0;
            default: s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // cpm_clock_power_ctrl

/* logic/cpm_core_divider.sv */
`timescale 1ns/1ps
// Turns source ticks into a core clock enable pulse every 2^div ticks.
module cpm_core_divider
   import cpm_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Control.
   input wire logic src_tick,
   input wire logic halt,
   input wire logic [2:0] div_sel,
   // Result.
   output logic core_en
);

   logic [DIV_CNT_W-1:0] cnt_ff; // Ticks seen in the current period.
   logic [DIV_CNT_W-1:0] last_cnt; // Terminal count for this divider.

   // The terminal count is 2^div minus one.
   assign last_cnt = DIV_CNT_W'((DIV_CNT_W'(1) << div_sel) - DIV_CNT_W'(1));

   // Count source ticks; a halt freezes the count so the phase resumes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= '0;
         core_en <= 1'b0;
      end else if (src_tick && !halt) begin
         if (cnt_ff >= last_cnt) begin
            cnt_ff <= '0;
            core_en <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff + DIV_CNT_W'(1);
            core_en <= 1'b0;
         end
      end else begin
         core_en <= 1'b0;
      end
   end

endmodule // cpm_core_divider

/* logic/cpm_pkg.sv */
// Summary of operation
// - Reference select bit 5 resets internal; clear selects crystal.
// - Lost lock halts core clock, raises interrupt, unless mode is external.
// - Mode field 1:0: 01 PLL default, 11 external.
// - Each power mode keeps its listed domains powered.
// - Power field 6:4 selects active through stop.
// - Sleep wakes on external lines or second timer.
// - Stop wakes only on external interrupt lines.
// - Divider field 2:0 divides PLL output by power-two.
// - Clock config written only between keys AA/55.
// - Power config written only between keys 01/F4.
// - PLL output is reference times 1275; core divides it.
package cpm_pkg;

   // Register byte addresses.
   localparam logic [31:0] PWR_KEY1_ADDR = 32'hffff0404;
   localparam logic [31:0] PWR_CFG_ADDR = 32'hffff0408;
   localparam logic [31:0] PWR_KEY2_ADDR = 32'hffff040c;
   localparam logic [31:0] CLK_KEY1_ADDR = 32'hffff0410;
   localparam logic [31:0] CLK_CFG_ADDR = 32'hffff0414;
   localparam logic [31:0] CLK_KEY2_ADDR = 32'hffff0418;
   localparam logic [31:0] IRQ_STAT_ADDR = 32'hffff0420;
   localparam logic [31:0] IRQ_CLR_ADDR = 32'hffff0424;
   localparam logic [31:0] IRQ_EN_ADDR = 32'hffff0428;

   // Key values of the two unlock sequences.
   localparam logic [15:0] CLK_KEY1_VAL = 16'h00aa;
   localparam logic [15:0] CLK_KEY2_VAL = 16'h0055;
   localparam logic [15:0] PWR_KEY1_VAL = 16'h0001;
   localparam logic [15:0] PWR_KEY2_VAL = 16'h00f4;

   // Reset values and implemented bits of the configuration registers.
   localparam logic [7:0] CLK_CFG_RST = 8'h21;
   localparam logic [7:0] CLK_CFG_MASK = 8'h23;
   localparam logic [7:0] PWR_CFG_RST = 8'h03;
   localparam logic [7:0] PWR_CFG_MASK = 8'h77;

   // Field positions.
   localparam int REF_SEL_BIT = 5;
   localparam int SRC_MODE_LSB = 0;
   localparam int PWR_MODE_LSB = 4;
   localparam int CORE_DIV_LSB = 0;

   // Clock source codes.
   localparam logic [1:0] SRC_PLL = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h3;

   // Power mode codes.
   localparam logic [2:0] PM_ACTIVE = 3'h0;
   localparam logic [2:0] PM_PAUSE = 3'h1;
   localparam logic [2:0] PM_NAP = 3'h2;
   localparam logic [2:0] PM_SLEEP = 3'h3;
   localparam logic [2:0] PM_STOP = 3'h4;

   // PLL multiplication of the reference, kept for software and models.
   localparam int PLL_MULT = 1275;

   // Interrupt event bit positions.
   localparam int EVT_UNLOCK = 0;
   localparam int EVT_WAKE = 1;
   localparam int EVT_W = 2;

   // Synchroniser depth and the divider counter width.
   localparam int SYNC_STAGES = 3;
   localparam int DIV_CNT_W = 8;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Power domain enables driven to the rest of the chip.
   typedef struct packed {
      logic core;
      logic periph;
      logic pll;
      logic xtal_timers;
      logic ext_irq;
   } cpm_domains_t;

   // One accepted register write.
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } cpm_wr_t;

   // Progress through a key-protected write.
   typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED, KEY_HELD} cpm_key_state_t;

endpackage

/* verif/cpm_ctrl_asserts.sv */
`timescale 1ns/1ps
// Port-level checks for the clock and power controller.
module cpm_ctrl_asserts
   import cpm_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Clock system.
   input wire logic pll_locked,
   input wire logic ref_internal_sel,
   input wire logic [1:0] clock_source_mode,
   input wire logic core_clk_en,
   input wire logic core_halted,
   input wire cpm_domains_t domains
);
   // All checks share the bus clock and its reset.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reset_state: assert property ($rose(aresetn) |-> ref_internal_sel
      && clock_source_mode == SRC_PLL && domains == 5'h1f)
      else $error("config outputs not at reset state");
   a_lock_halts: assert property ($fell(pll_locked)
      && clock_source_mode == SRC_PLL |-> ##[1:6] core_halted)
      else $error("lost lock did not halt the core");
   a_halt_no_tick: assert property ($past(core_halted) |-> !core_clk_en)
      else $error("core enable pulsed while halted");
   a_domain_nesting: assert property (domains.ext_irq
      && (domains.core -> domains.periph) && (domains.periph -> domains.pll)
      && (domains.pll -> domains.xtal_timers))
      else $error("power domains not nested");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule // cpm_ctrl_asserts

bind cpm_clock_power_ctrl cpm_ctrl_asserts u_chk (.aclk(aclk),
   .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .pll_locked(pll_locked),
   .ref_internal_sel(ref_internal_sel),
   .clock_source_mode(clock_source_mode), .core_clk_en(core_clk_en),
   .core_halted(core_halted), .domains(domains));

/* verif/test_clock_power_mode_control.sv */
`timescale 1ns/1ps
// Self-checking bench: drives the bus and pins, mirrors the key logic.
module test_clock_power_mode_control;
   import cpm_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata, v, rnd;
   logic pll_locked, ext_pin, tmr_evt, awready, wready, bvalid;
   logic arready, rvalid, ref_sel, core_en, halted, irq;
   logic [3:0] xirq;
   logic [1:0] bresp, rresp, src_mode;
   cpm_domains_t domains;
   int error_cnt, n_checks, kst, pend, g;
   int clk_m = 'h21; // Mirror of the clock configuration.
   int pwr_m = 'h03; // Mirror of the power configuration.
   logic [4:0] dom_tab [5] = '{5'h1f, 5'h0f, 5'h07, 5'h03, 5'h01};

   cpm_clock_power_ctrl u_cpm_clock_power_ctrl (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pll_locked(pll_locked),
      .ext_clock_pin(ext_pin), .external_irq_lines(xirq),
      .second_timer_event(tmr_evt), .ref_internal_sel(ref_sel),
      .clock_source_mode(src_mode), .core_clk_en(core_en),
      .core_halted(halted), .domains(domains), .irq(irq));

   // Free-running bus clock, 25 ns period.
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // Prints counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // A spent wait bound counts as a mismatch and closes the run.
   task automatic bound(input int n);
      if (n >= 300) begin
         error_cnt++;
         report_and_stop();
      end
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Model of the unlock sequences; any stray write drops the sequence.
   task automatic m_write(input logic [31:0] a, d);
      if (kst == 2 && a == CLK_KEY2_ADDR && d[15:0] == CLK_KEY2_VAL)
         clk_m = pend & 'h23;
      if (kst == 4 && a == PWR_KEY2_ADDR && d[15:0] == PWR_KEY2_VAL)
         pwr_m = pend & 'h77;
      if (a == CLK_KEY1_ADDR && d[15:0] == CLK_KEY1_VAL) kst = 1;
      else if (a == PWR_KEY1_ADDR && d[15:0] == PWR_KEY1_VAL) kst = 3;
      else if ((kst == 1 && a == CLK_CFG_ADDR) ||
               (kst == 3 && a == PWR_CFG_ADDR)) begin
         pend = d;
         kst++;
      end
      else kst = 0;
   endtask

   // One write; entered and left just after a rising edge.
   task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
      int n;
      logic da, dw, hb, ta, tw;
      logic [1:0] r;
      n = 0;
      da = 1'b0;
      dw = 1'b0;
      hb = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(da && dw && hb) && n < 300) begin
         @(negedge aclk);
         hb = da && dw && bvalid === 1'b1;
         r = bresp;
         ta = !da && awready === 1'b1;
         tw = !dw && wready === 1'b1;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         da = da || ta;
         dw = dw || tw;
         n++;
      end
      bound(n);
      chk("bresp", 32'(r), 32'(er));
      m_write(a, d);
   endtask

   task automatic rd(input logic [31:0] a, input logic [1:0] er,
                     output logic [31:0] d);
      int n;
      logic ha, hr, ta;
      n = 0;
      ha = 1'b0;
      hr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hr && n < 300) begin
         @(negedge aclk);
         hr = ha && rvalid === 1'b1;
         d = rdata;
         ta = !ha && arready === 1'b1;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         ha = ha || ta;
         n++;
      end
      bound(n);
      chk("rresp", 32'(rresp), 32'(er));
   endtask

   task automatic seq(input logic [31:0] k1, a, k2, input int val);
      wr(k1 + 32'h0, (k1 == CLK_KEY1_ADDR) ? 32'(CLK_KEY1_VAL)
         : 32'(PWR_KEY1_VAL), RESP_OKAY);
      wr(a, 32'(val), RESP_OKAY);
      wr(k2, (k2 == CLK_KEY2_ADDR) ? 32'(CLK_KEY2_VAL)
         : 32'(PWR_KEY2_VAL), RESP_OKAY);
   endtask

   // Compares both configurations and the clock-select outputs.
   task automatic regs();
      rd(CLK_CFG_ADDR, RESP_OKAY, v);
      chk("clock_config", v, 32'(clk_m));
      rd(PWR_CFG_ADDR, RESP_OKAY, v);
      chk("power_config", v, 32'(pwr_m));
      chk("ref_sel", 32'(ref_sel), 32'(clk_m[5]));
      chk("src_mode", 32'(src_mode), 32'(clk_m[1:0]));
   endtask

   task automatic wait_halt(input logic want);
      int n;
      n = 0;
      while (halted !== want && n < 300) begin
         @(negedge aclk);
         n++;
      end
      bound(n);
      @(negedge aclk);
      @(posedge aclk);
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, wdata, araddr} = 96'h0;
      {ext_pin, tmr_evt, xirq} = 6'h0;
      {error_cnt, n_checks, kst, pend} = 0;
      pll_locked = 1'b1;
      rnd = 32'h36;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      regs();
      chk("domains", 32'(domains), 32'h1f);
      foreach (dom_tab[i]) begin
         rd(32'hffff0404 + 32'(i * 4) + ((i > 2) ? 32'h4 : 32'h0),
            RESP_OKAY, v);
         if (i != 1 && i != 3) chk("key_read", v, 32'h0);
      end
      rd(32'hffff0500, RESP_SLVERR, v);
      chk("unmapped", v, 32'h0);
      $display("test reset done");
      wr(CLK_CFG_ADDR, 32'h23, RESP_OKAY);
      seq(CLK_KEY1_ADDR, CLK_CFG_ADDR, PWR_KEY2_ADDR, 'h23);
      wr(CLK_KEY1_ADDR, 32'haa, RESP_OKAY);
      wr(32'hffff0500, 32'h0, RESP_SLVERR);
      wr(CLK_CFG_ADDR, 32'h23, RESP_OKAY);
      wr(CLK_KEY2_ADDR, 32'h55, RESP_OKAY);
      regs();
      seq(CLK_KEY1_ADDR, CLK_CFG_ADDR, CLK_KEY2_ADDR, 'h01);
      regs();
      $display("test keys done");
      for (int i = 0; i < 8; i++) begin
         rnd = rnd ^ (rnd << 13);
         rnd = rnd ^ (rnd >> 17);
         rnd = rnd ^ (rnd << 5);
         seq(PWR_KEY1_ADDR, PWR_CFG_ADDR, PWR_KEY2_ADDR, i | (rnd & 'h88));
         regs();
         g = 0;
         do begin
            @(negedge aclk);
            g++;
         end while (core_en !== 1'b1 && g < 300);
         bound(g);
         g = 0;
         do begin
            @(negedge aclk);
            g++;
         end while (core_en !== 1'b1 && g < 300);
         @(posedge aclk);
         chk("core_gap", 32'(g), 32'(1 << i));
      end
      $display("test divider done");
      wr(IRQ_EN_ADDR, 32'h2, RESP_OKAY);
      for (int pm = 1; pm < 5; pm++) begin
         seq(PWR_KEY1_ADDR, PWR_CFG_ADDR, PWR_KEY2_ADDR, pm << 4);
         regs();
         chk("domains", 32'(domains), 32'(dom_tab[pm]));
         tmr_evt <= 1'b1;
         @(posedge aclk);
         tmr_evt <= 1'b0;
         repeat (6) @(posedge aclk);
         if (pm == 4) begin
            regs();
            xirq <= 4'h1 << rnd[1:0];
         end
         wait_halt(1'b0);
         xirq <= 4'h0;
         pwr_m = pwr_m & 'h0f;
         regs();
         chk("irq", 32'(irq), 32'h1);
         wr(IRQ_CLR_ADDR, 32'h2, RESP_OKAY);
         chk("irq", 32'(irq), 32'h0);
      end
      $display("test modes done");
      wr(IRQ_EN_ADDR, 32'h1, RESP_OKAY);
      pll_locked <= 1'b0;
      wait_halt(1'b1);
      chk("irq", 32'(irq), 32'h1);
      rd(IRQ_STAT_ADDR, RESP_OKAY, v);
      chk("status", v, 32'h1);
      pll_locked <= 1'b1;
      wait_halt(1'b0);
      wr(IRQ_CLR_ADDR, 32'h1, RESP_OKAY);
      chk("irq", 32'(irq), 32'h0);
      seq(CLK_KEY1_ADDR, CLK_CFG_ADDR, CLK_KEY2_ADDR, 'h23);
      regs();
      pll_locked <= 1'b0;
      g = 0;
      for (int t = 1; t <= 40; t++) begin
         @(posedge aclk);
         if (core_en === 1'b1) g++;
         if (t % 4 == 0) ext_pin <= ~ext_pin;
      end
      chk("ext_ticks", 32'(g), 32'h4);
      chk("halted", 32'(halted), 32'h0);
      chk("irq", 32'(irq), 32'h0);
      pll_locked <= 1'b1;
      $display("test clock source done");
      report_and_stop();
   end

   // Hang guard.
   initial begin
      repeat (60000) @(posedge aclk);
      bound(300);
   end
endmodule // test_clock_power_mode_control
